// >>> rtl/irg_pkg.sv
// Purpose: Shared constants and types of the initial reset generator
// Assumes: Slow oscillator near 32.768 kHz, ref_clk at 10 MHz
// Notes:   Timing counts are derived from times in their own units
package irg_pkg;

  // Slow oscillator and divided release tick
  localparam int SLOW_HZ        = 32768;
  localparam int TICK_HZ        = 2;
  localparam int DIV_HALF_TICKS = SLOW_HZ / (2 * TICK_HZ);
  // Key noise reject: least time, rounded up to whole slow periods
  localparam int NOISE_US       = 1500;
  localparam int NOISE_TICKS    = (NOISE_US * SLOW_HZ + 999999) / 1000000;
  // Time qualifier: lower end of the 1 to 2 s window
  localparam int QUAL_MS        = 1000;
  localparam int QUAL_TICKS     = (QUAL_MS * SLOW_HZ + 999) / 1000;

  // Core restart values
  localparam logic [15:0] PC_RESET_VAL = 16'h0110;

  // Key combination options
  localparam int KEY_OPT_NONE = 1;
  localparam int KEY_OPT_ALL4 = 2;
  localparam int KEY_OPT_K012 = 3;
  localparam int KEY_OPT_K01  = 4;
  localparam logic [3:0] KEY_MASK_ALL4 = 4'hf;
  localparam logic [3:0] KEY_MASK_K012 = 4'h7;
  localparam logic [3:0] KEY_MASK_K01  = 4'h3;

  // Register map (byte addresses)
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam int         CTRL_LVL_BIT  = 0;
  localparam logic       CTRL_LVL_RST  = 1'b0;
  localparam int         ST_HELD_BIT   = 0;
  localparam int         ST_BLOCK_BIT  = 1;
  localparam int         ST_KEYLOW_BIT = 2;
  localparam int         ST_PREFIX_BIT = 3;
  localparam int         ST_LVL_BIT    = 4;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Reset sequencer states
  typedef enum logic [2:0] {
    S_RUN  = 3'h1,
    S_HELD = 3'h2,
    S_LOAD = 3'h4
  } irg_state_t;

  // Events from the core
  typedef struct packed {
    logic wide_sp_wr;       // Wide stack pointer written
    logic nibble_sp_wr;     // Nibble stack pointer written
    logic prefix_wr;        // Address prefix register written
    logic instr_done;       // One instruction completed
  } irg_core_req_t;

  // Initial state handed to the core
  typedef struct packed {
    logic        pc_load;   // One-cycle load of pc_value
    logic [15:0] pc_value;  // Restart address
    logic        int_clr;   // Clear interrupt flag
    logic        prefix_flag; // Next instruction uses extended addressing
    logic        irq_block; // All interrupts incl. non-maskable blocked
  } irg_core_init_t;

endpackage : irg_pkg

// >>> rtl/irg_sync3.sv
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Inputs are asynchronous to clk
// Notes:   A change is taken once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module irg_sync3 #(
  parameter int         W    = 1,
  parameter logic [W-1:0] INIT = '1
) (
  input  wire logic         clk,     // Sampling clock
  input  wire logic         rst_n,   // Async reset, active low
  input  wire logic [W-1:0] din,     // Raw pin level
  output logic      [W-1:0] dout     // Filtered level
);

  logic [W-1:0] s1_ff, s2_ff, s3_ff, out_ff;
  logic [W-1:0] nxt_out;

  // Only the second stage looks at the first
  always_comb begin
    nxt_out = out_ff;
    for (int i = 0; i < W; i++) begin
      if (s2_ff[i] == s3_ff[i]) begin
        nxt_out[i] = s3_ff[i];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff  <= INIT;
      s2_ff  <= INIT;
      s3_ff  <= INIT;
      out_ff <= INIT;
    end else begin
      s1_ff  <= din;
      s2_ff  <= s1_ff;
      s3_ff  <= s2_ff;
      out_ff <= nxt_out;
    end
  end

  assign dout = out_ff;

endmodule : irg_sync3
`default_nettype wire

// >>> rtl/irg_lowtimer.sv
// Purpose: Counts slow ticks while a condition holds
// Assumes: tick is a one-cycle pulse per slow oscillator period
// Notes:   Count restarts as soon as active drops
`timescale 1ns/1ps
`default_nettype none
module irg_lowtimer #(
  parameter int N = 50,
  parameter int W = $clog2(N + 1)
) (
  input  wire logic clk,     // Clock
  input  wire logic rst_n,   // Async reset, active low
  input  wire logic tick,    // Slow oscillator tick
  input  wire logic active,  // Condition being timed
  output logic      done     // Condition held N ticks
);

  logic [W-1:0] cnt_ff, nxt_cnt;
  logic         done_ff, nxt_done;

  // Saturating count; no oscillator means no ticks, so nothing completes
  always_comb begin
    nxt_cnt = cnt_ff;
    if (!active) begin
      nxt_cnt = '0;
    end else if (tick && (cnt_ff != W'(N))) begin
      nxt_cnt = cnt_ff + W'(1);
    end
    nxt_done = active && (nxt_cnt == W'(N));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff  <= '0;
      done_ff <= 1'b0;
    end else begin
      cnt_ff  <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign done = done_ff;

endmodule : irg_lowtimer
`default_nettype wire

// >>> rtl/irg_reset_gen.sv
// Purpose: Initial reset generator with key reset and supply select
// Assumes: Pins are asynchronous; core events are on ref_clk
// Notes:   Registers over AXI4-Lite; one write and one read at a time
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Low reset pin sets latch holding reset
// - Latch clears only on 2 Hz tick high
// - Reset from pin or key combination
// - Key combination filtered, 1.5 ms low needed
// - Filter idle until slow oscillator runs
// - Option picks key set or disables it
// - All four option needs every key low
// - Partial option ignores unselected keys
// - Optional qualifier needs 1 to 2 s low
// - Reset loads PC 0110h, clears I and E
// - Interrupts blocked until both stack pointers written
// - Prefix write sets flag for next instruction
// - Supply level 1.3 V or 2.2 V by software
// - RC slow oscillator forces 2.2 V level
// - Level bit one means 2.2 V, resets zero
module irg_reset_gen
  import irg_pkg::*;
#(
  parameter int         KEY_OPT   = KEY_OPT_ALL4,
  parameter bit         TIME_QUAL = 1'b0,
  parameter bit         SLOW_RC   = 1'b0,
  parameter int         DIV_HALF  = DIV_HALF_TICKS,
  parameter int         NOISE_N   = NOISE_TICKS,
  parameter int         QUAL_N    = QUAL_TICKS
) (
  input  wire logic           ref_clk,        // 10 MHz clock
  input  wire logic           reset_n,        // Async power-on reset
  input  wire logic           reset_pin_n,    // Reset pin, low requests
  input  wire logic           slow_oscillator, // Slow oscillator level
  input  wire logic [3:0]     key_input_bits, // Key input port
  input  wire irg_core_req_t  core_req,       // Core events
  output irg_core_init_t      core_init,      // Core initial state
  output logic                init_reset_n,   // Internal reset, low active
  output logic                internal_logic_supply, // 1: 2.2 V, 0: 1.3 V
  input  wire logic [7:0]     s_axi_awaddr,   // Write address
  input  wire logic           s_axi_awvalid,  // Write address valid
  output logic                s_axi_awready,  // Write address ready
  input  wire logic [31:0]    s_axi_wdata,    // Write data
  input  wire logic [3:0]     s_axi_wstrb,    // Write strobes
  input  wire logic           s_axi_wvalid,   // Write data valid
  output logic                s_axi_wready,   // Write data ready
  output logic [1:0]          s_axi_bresp,    // Write response
  output logic                s_axi_bvalid,   // Write response valid
  input  wire logic           s_axi_bready,   // Write response ready
  input  wire logic [7:0]     s_axi_araddr,   // Read address
  input  wire logic           s_axi_arvalid,  // Read address valid
  output logic                s_axi_arready,  // Read address ready
  output logic [31:0]         s_axi_rdata,    // Read data
  output logic [1:0]          s_axi_rresp,    // Read response
  output logic                s_axi_rvalid,   // Read data valid
  input  wire logic           s_axi_rready    // Read data ready
);

  localparam int DW = $clog2(DIV_HALF);

  // Selected key mask per build option
  localparam logic [3:0] KEY_MASK =
    (KEY_OPT == KEY_OPT_ALL4) ? KEY_MASK_ALL4 :
    (KEY_OPT == KEY_OPT_K012) ? KEY_MASK_K012 :
    (KEY_OPT == KEY_OPT_K01)  ? KEY_MASK_K01  : 4'h0;

  logic       pin_n_s, slow_s;
  logic [3:0] key_s;
  logic       slow_prev_ff, slow_tick;
  logic       keys_low, noise_done, qual_done, key_reset;

  // Pins pass the three-stage synchroniser
  irg_sync3 #(.W(1), .INIT(1'b0)) u_sync_pin (
    .clk   (ref_clk),
    .rst_n (reset_n),
    .din   (reset_pin_n),
    .dout  (pin_n_s)
  );

  irg_sync3 #(.W(1), .INIT(1'b0)) u_sync_slow (
    .clk   (ref_clk),
    .rst_n (reset_n),
    .din   (slow_oscillator),
    .dout  (slow_s)
  );

  irg_sync3 #(.W(4), .INIT(4'hf)) u_sync_key (
    .clk   (ref_clk),
    .rst_n (reset_n),
    .din   (key_input_bits),
    .dout  (key_s)
  );

  // Rising edge of the slow oscillator; none until it starts
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      slow_prev_ff <= 1'b0;
    end else begin
      slow_prev_ff <= slow_s;
    end
  end
  assign slow_tick = slow_s & ~slow_prev_ff;

  // Selected keys all low; unselected keys play no part
  assign keys_low = (KEY_OPT != KEY_OPT_NONE) &&
                    ((key_s & KEY_MASK) == 4'h0);

  // Noise reject, restarted whenever a selected key goes high
  irg_lowtimer #(.N(NOISE_N)) u_noise (
    .clk    (ref_clk),
    .rst_n  (reset_n),
    .tick   (slow_tick),
    .active (keys_low),
    .done   (noise_done)
  );

  // Optional time qualifier after the noise filter
  irg_lowtimer #(.N(QUAL_N)) u_qual (
    .clk    (ref_clk),
    .rst_n  (reset_n),
    .tick   (slow_tick),
    .active (noise_done),
    .done   (qual_done)
  );

  assign key_reset = TIME_QUAL ? qual_done : noise_done;

  // Free running divider gives the 2 Hz release tick
  logic [DW-1:0] div_ff, nxt_div;
  logic          hz2_ff, nxt_hz2;

  always_comb begin
    nxt_div = div_ff;
    nxt_hz2 = hz2_ff;
    if (slow_tick) begin
      if (div_ff == DW'(DIV_HALF - 1)) begin
        nxt_div = '0;
        nxt_hz2 = ~hz2_ff;
      end else begin
        nxt_div = div_ff + DW'(1);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_ff <= '0;
      hz2_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      hz2_ff <= nxt_hz2;
    end
  end

  // Reset latch sequencer: held state is the latch
  irg_state_t state_ff, nxt_state;
  logic       set_req;

  assign set_req = ~pin_n_s | key_reset;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      S_RUN: begin
        if (set_req) begin
          nxt_state = S_HELD;
        end
      end
      S_HELD: begin
        // Set wins over the tick; only a high tick releases
        if (!set_req && hz2_ff) begin
          nxt_state = S_LOAD;
        end
      end
      S_LOAD: begin
        nxt_state = set_req ? S_HELD : S_RUN;
      end
      default: begin
        nxt_state = S_HELD;
      end
    endcase
  end

  // Power-on enters the held state so the core never runs unreset
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= S_HELD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Pin low asserts at once; release follows the latch
  assign init_reset_n = reset_n & reset_pin_n &
                        (state_ff != S_HELD);

  // Core initial state and interrupt blocking
  logic sp1_ok_ff, sp2_ok_ff, nxt_sp1_ok, nxt_sp2_ok;
  logic pre_ff, nxt_pre;
  logic load_ff, nxt_load;
  logic iclr_ff, nxt_iclr;

  always_comb begin
    nxt_sp1_ok = sp1_ok_ff;
    nxt_sp2_ok = sp2_ok_ff;
    nxt_pre    = pre_ff;
    nxt_load   = (state_ff == S_LOAD);
    nxt_iclr   = (state_ff != S_RUN);
    if (state_ff != S_RUN) begin
      nxt_sp1_ok = 1'b0;
      nxt_sp2_ok = 1'b0;
      nxt_pre    = 1'b0;
    end else begin
      // Re-writing one pointer of a set pair blocks until the other
      if (core_req.wide_sp_wr) begin
        nxt_sp1_ok = 1'b1;
        if (!core_req.nibble_sp_wr && sp1_ok_ff && sp2_ok_ff) begin
          nxt_sp2_ok = 1'b0;
        end
      end
      if (core_req.nibble_sp_wr) begin
        nxt_sp2_ok = 1'b1;
        if (!core_req.wide_sp_wr && sp1_ok_ff && sp2_ok_ff) begin
          nxt_sp1_ok = 1'b0;
        end
      end
      // Prefix lasts for exactly the following instruction
      if (core_req.prefix_wr) begin
        nxt_pre = 1'b1;
      end else if (core_req.instr_done) begin
        nxt_pre = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sp1_ok_ff <= 1'b0;
      sp2_ok_ff <= 1'b0;
      pre_ff    <= 1'b0;
      load_ff   <= 1'b0;
      iclr_ff   <= 1'b1;
    end else begin
      sp1_ok_ff <= nxt_sp1_ok;
      sp2_ok_ff <= nxt_sp2_ok;
      pre_ff    <= nxt_pre;
      load_ff   <= nxt_load;
      iclr_ff   <= nxt_iclr;
    end
  end

  assign core_init.pc_load     = load_ff;
  assign core_init.pc_value    = PC_RESET_VAL;
  assign core_init.int_clr     = iclr_ff;
  assign core_init.prefix_flag = pre_ff;
  assign core_init.irq_block   = ~(sp1_ok_ff & sp2_ok_ff);

  // Supply level select; internal reset returns it to 1.3 V, or to 2.2 V with SLOW_RC
  logic lvl_ff, nxt_lvl;
  logic lvl_out_ff;

  // Write channel: address and data taken in either order
  logic       aw_have_ff, nxt_aw_have;
  logic [7:0] aw_addr_ff, nxt_aw_addr;
  logic       w_have_ff, nxt_w_have;
  logic       w_bit_ff, nxt_w_bit;
  logic       w_lane_ff, nxt_w_lane;
  logic       bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;

  assign s_axi_awready = ~aw_have_ff & ~bvalid_ff;
  assign s_axi_wready  = ~w_have_ff & ~bvalid_ff;

  always_comb begin
    nxt_aw_have = aw_have_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_have  = w_have_ff;
    nxt_w_bit   = w_bit_ff;
    nxt_w_lane  = w_lane_ff;
    nxt_bvalid  = bvalid_ff;
    nxt_bresp   = bresp_ff;
    nxt_lvl     = lvl_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_aw_have = 1'b1;
      nxt_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_w_have = 1'b1;
      nxt_w_bit  = s_axi_wdata[CTRL_LVL_BIT];
      nxt_w_lane = s_axi_wstrb[0];
    end
    // Commit one cycle after both halves are held
    if (aw_have_ff && w_have_ff) begin
      nxt_aw_have = 1'b0;
      nxt_w_have  = 1'b0;
      nxt_bvalid  = 1'b1;
      if (aw_addr_ff == REG_CTRL) begin
        nxt_bresp = RESP_OKAY;
        if (w_lane_ff) begin
          nxt_lvl = w_bit_ff;
        end
      end else if (aw_addr_ff == REG_STATUS) begin
        nxt_bresp = RESP_OKAY;  // Status is read only
      end else begin
        nxt_bresp = RESP_SLVERR;
      end
    end else if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
    if (state_ff != S_RUN) begin
      nxt_lvl = CTRL_LVL_RST;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_have_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_have_ff  <= 1'b0;
      w_bit_ff   <= 1'b0;
      w_lane_ff  <= 1'b0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
      lvl_ff     <= CTRL_LVL_RST;
      lvl_out_ff <= SLOW_RC;
    end else begin
      aw_have_ff <= nxt_aw_have;
      aw_addr_ff <= nxt_aw_addr;
      w_have_ff  <= nxt_w_have;
      w_bit_ff   <= nxt_w_bit;
      w_lane_ff  <= nxt_w_lane;
      bvalid_ff  <= nxt_bvalid;
      bresp_ff   <= nxt_bresp;
      lvl_ff     <= nxt_lvl;
      lvl_out_ff <= SLOW_RC | nxt_lvl;
    end
  end

  assign s_axi_bvalid          = bvalid_ff;
  assign s_axi_bresp           = bresp_ff;
  assign internal_logic_supply = lvl_out_ff;

  // Read channel: answer on the same edge that takes the address
  logic        rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0]  rresp_ff, nxt_rresp;

  assign s_axi_arready = ~rvalid_ff;

  always_comb begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rvalid = 1'b1;
      nxt_rdata  = 32'h0;
      nxt_rresp  = RESP_OKAY;
      if (s_axi_araddr == REG_CTRL) begin
        nxt_rdata[CTRL_LVL_BIT] = lvl_ff;
      end else if (s_axi_araddr == REG_STATUS) begin
        nxt_rdata[ST_HELD_BIT]   = (state_ff == S_HELD);
        nxt_rdata[ST_BLOCK_BIT]  = ~(sp1_ok_ff & sp2_ok_ff);
        nxt_rdata[ST_KEYLOW_BIT] = noise_done;
        nxt_rdata[ST_PREFIX_BIT] = pre_ff;
        nxt_rdata[ST_LVL_BIT]    = lvl_out_ff;
      end else begin
        nxt_rresp = RESP_SLVERR;
      end
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0;
      rresp_ff  <= RESP_OKAY;
    end else begin
      rvalid_ff <= nxt_rvalid;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rresp;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;

endmodule : irg_reset_gen
`default_nettype wire

// >>> verification/irg_reset_monitor.sv
// Purpose: Port checks of the initial reset generator
// Assumes: Bound onto every generator instance
// Notes:   Key timing is judged by the bench, not here
`timescale 1ns/1ps
`default_nettype none
module irg_reset_monitor
  import irg_pkg::*;
#(
  parameter bit SLOW_RC = 1'b0
) (
  input wire logic           ref_clk,              // Clock
  input wire logic           reset_n,              // Block reset
  input wire logic           reset_pin_n,          // Reset pin
  input wire irg_core_req_t  core_req,             // Core events
  input wire irg_core_init_t core_init,            // Core state
  input wire logic           init_reset_n,         // Internal reset
  input wire logic           internal_logic_supply // Supply level
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Core runs once the restart sequence is over
  wire logic run = init_reset_n && !core_init.int_clr;

  // Release, restart load and flags
  pin_hold_a: assert property (!reset_pin_n |-> !init_reset_n)
    else $error("pin low but reset free");
  load_after_a: assert property ($rose(init_reset_n) |->
    ##[0:2] (core_init.pc_load && core_init.pc_value == 16'h0110))
    else $error("no restart load");
  load_pulse_a: assert property (core_init.pc_load |=> !core_init.pc_load)
    else $error("restart load too long");
  restart_flags_a: assert property ($rose(init_reset_n) |-> core_init.int_clr &&
    core_init.irq_block && !core_init.prefix_flag)
    else $error("flags not reset");
  held_clr_a: assert property (!init_reset_n [*8] |-> core_init.int_clr)
    else $error("interrupt flag kept in reset");
  supply_rst_a: assert property ($rose(init_reset_n) |->
    internal_logic_supply == SLOW_RC)
    else $error("supply level not reset");

  // Stack pointer pairing and prefix
  sp_pair_a: assert property (run && core_req.wide_sp_wr && core_req.nibble_sp_wr
    |=> !core_init.irq_block)
    else $error("block kept after both pointers");
  // Only a re-write of one pointer of an already set pair blocks again
  sp_single_a: assert property (run && !core_init.irq_block && core_req.wide_sp_wr &&
    !core_req.nibble_sp_wr |=> core_init.irq_block)
    else $error("block not restored by one pointer");
  prefix_set_a: assert property (run && core_req.prefix_wr |=> core_init.prefix_flag)
    else $error("prefix flag not set");

  // Main scenarios reached
  cover property (core_init.pc_load);
  cover property ($fell(core_init.irq_block));
  cover property (run && internal_logic_supply);
endmodule : irg_reset_monitor
`default_nettype wire

// >>> verification/irg_ext_party.sv
// Purpose: Reset switch, key pad and slow oscillator
// Assumes: Oscillator scaled to SLOW_HALF ref_clk cycles a half period
// Notes:   Short presses are stretched to the least accepted width
`timescale 1ns/1ps
`default_nettype none
module irg_ext_party #(
  parameter int SLOW_HALF = 4,
  parameter int MIN_LOW   = 1000,
  parameter int PWR_LOW   = 20001
) (
  input  wire logic       ref_clk,         // Bench clock
  input  wire logic       press,           // Request a pin reset
  input  wire logic [3:0] keys_req,        // Keys, 0 = pressed
  output logic            reset_pin_n,     // Reset pin
  output logic            slow_oscillator, // Slow oscillator
  output logic [3:0]      key_input_bits   // Key port, pulled up
);
  int pin_cnt_ff = PWR_LOW; // Power-up: low from time zero, over 2 ms
  int osc_cnt_ff = 0;
  initial begin
    reset_pin_n = 1'b0;
    slow_oscillator = 1'b0;
    key_input_bits = 4'hf;
  end
  // Pin never low shorter than 0.1 ms; oscillator free-running
  always @(posedge ref_clk) begin
    if (press) pin_cnt_ff <= MIN_LOW;
    else if (pin_cnt_ff > 0) pin_cnt_ff <= pin_cnt_ff - 1;
    reset_pin_n <= !(press || pin_cnt_ff > 1);
    osc_cnt_ff <= (osc_cnt_ff == SLOW_HALF - 1) ? 0 : osc_cnt_ff + 1;
    if (osc_cnt_ff == SLOW_HALF - 1) slow_oscillator <= !slow_oscillator;
    key_input_bits <= keys_req; // Not stretched; the bench sets how long each key is held
  end
endmodule : irg_ext_party
`default_nettype wire

// >>> verification/irg_reset_gen_tb.sv
// Purpose: Self-checking bench of the initial reset generator
// Assumes: Slow counts scaled down by parameters
// Notes:   Instance k01 covers the partial key set with qualifier and RC supply
`timescale 1ns/1ps
`default_nettype none
module irg_reset_gen_tb;
  import irg_pkg::*;
  localparam int HALF = 4; // Slow half period in ref_clk cycles
  typedef struct packed {
    logic [3:0] keys;
    logic [7:0] ticks;
    logic exp_a;
    logic exp_b;
  } irg_key_row_t;
  typedef struct packed {
    irg_core_req_t req;
    logic blk;
    logic pre;
  } irg_core_row_t;
  // Keys, slow periods held, reset on all-four and on two-key qualified instance
  irg_key_row_t key_rows [7] = '{'{4'hf, 8'h14, 1'b0, 1'b0}, '{4'h0, 8'h14, 1'b1, 1'b1},
    '{4'h8, 8'h14, 1'b0, 1'b1}, '{4'hc, 8'h14, 1'b0, 1'b1}, '{4'h1, 8'h14, 1'b0, 1'b0},
    '{4'h0, 8'h06, 1'b1, 1'b0}, '{4'h0, 8'h01, 1'b0, 1'b0}};
  // Core event, expected block and prefix flag
  irg_core_row_t core_rows [8] = '{'{4'h8, 1'b1, 1'b0}, '{4'h4, 1'b0, 1'b0},
    '{4'h8, 1'b1, 1'b0}, '{4'h4, 1'b0, 1'b0}, '{4'hc, 1'b0, 1'b0}, '{4'h2, 1'b0, 1'b1},
    '{4'h1, 1'b0, 1'b0}, '{4'h3, 1'b0, 1'b1}};
  logic ref_clk, reset_n, press, b_rst_n, reset_pin_n, slow_oscillator;
  logic init_reset_n, internal_logic_supply, b_supply;
  logic [3:0] keys_req, key_input_bits, s_axi_wstrb;
  irg_core_req_t core_req;
  irg_core_init_t core_init;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int miscompares = 0;
  int tests_run = 0;

  irg_ext_party #(.SLOW_HALF(HALF)) i_irg_ext_party (.*);
  irg_reset_gen #(.DIV_HALF(4), .NOISE_N(3), .QUAL_N(5)) i_irg_reset_gen (.*);
  irg_reset_gen #(.KEY_OPT(KEY_OPT_K01), .TIME_QUAL(1'b1), .DIV_HALF(4), .NOISE_N(3),
    .QUAL_N(5), .SLOW_RC(1'b1)) i_irg_reset_gen_k01 (.*, .core_init(), .init_reset_n(b_rst_n),
    .internal_logic_supply(b_supply), .s_axi_awready(), .s_axi_wready(), .s_axi_bresp(),
    .s_axi_bvalid(), .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid());

  // 10 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic complete_run;
    $display("Checks %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run

  task automatic timeout;
    miscompares++;
    $display("mismatch at %0t: got %h expected %h", $time, 1'b0, 1'b1);
    complete_run();
  endtask : timeout

  // Bounded wait for both internal resets to release
  task automatic wait_up(input int bound);
    int n;
    n = 0;
    while (!(init_reset_n === 1'b1 && b_rst_n === 1'b1)) begin
      @(posedge ref_clk);
      n++;
      if (n > bound) timeout();
    end
  endtask : wait_up

  // Address and data offered together, bready held until the response
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    // Let an edge pass so no handshake signal is driven twice in one step
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    if (n >= 50) timeout();
    check({30'h0, s_axi_bresp}, {30'h0, er});
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    s_axi_rready <= 1'b0;
    if (n >= 50) timeout();
    check(s_axi_rdata, ed);
    check({30'h0, s_axi_rresp}, {30'h0, er});
  endtask : axi_rd

  // Main sequence
  initial begin
    logic low_a, low_b;
    reset_n = 1'b0;
    {press, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
    {s_axi_awaddr, s_axi_araddr, keys_req, s_axi_wstrb} = 24'h00000ff;
    s_axi_wdata = 32'h0;
    core_req = 4'h0;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    check(init_reset_n, 1'b0);
    check(core_init.irq_block, 1'b1);
    check(internal_logic_supply, 1'b0);
    wait_up(30000);
    repeat (4) @(posedge ref_clk);
    axi_rd(REG_CTRL, 32'h0, RESP_OKAY);
    axi_rd(REG_STATUS, 32'h2, RESP_OKAY);
    axi_wr(REG_CTRL, 32'h1, RESP_OKAY);
    check(internal_logic_supply, 1'b1);
    axi_wr(REG_STATUS, 32'h0, RESP_OKAY);
    axi_wr(8'h08, 32'h1, RESP_SLVERR);
    axi_rd(8'h0c, 32'h0, RESP_SLVERR);
    axi_rd(REG_STATUS, 32'h12, RESP_OKAY);
    // Write without the low byte lane must leave the level alone
    s_axi_wstrb <= 4'h0;
    axi_wr(REG_CTRL, 32'h0, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    check(internal_logic_supply, 1'b1);
    axi_wr(REG_CTRL, 32'h0, RESP_OKAY);
    check(internal_logic_supply, 1'b0);
    check(b_supply, 1'b1);
    // Stack pointer pairing and prefix flag rows
    foreach (core_rows[i]) begin
      core_req <= core_rows[i].req;
      @(posedge ref_clk);
      core_req <= 4'h0;
      @(posedge ref_clk);
      check(core_init.irq_block, core_rows[i].blk);
      check(core_init.prefix_flag, core_rows[i].pre);
    end
    // Key combination rows, both options at once
    foreach (key_rows[i]) begin
      low_a = 1'b0;
      low_b = 1'b0;
      keys_req <= key_rows[i].keys;
      repeat (int'(key_rows[i].ticks) * 2 * HALF) begin
        @(posedge ref_clk);
        if (init_reset_n !== 1'b1) low_a = 1'b1;
        if (b_rst_n !== 1'b1) low_b = 1'b1;
      end
      keys_req <= 4'hf;
      check(low_a, key_rows[i].exp_a);
      check(low_b, key_rows[i].exp_b);
      wait_up(400);
      repeat (4) @(posedge ref_clk);
    end
    // Short press mid-run, level raised beforehand
    axi_wr(REG_CTRL, 32'h1, RESP_OKAY);
    press <= 1'b1;
    @(posedge ref_clk);
    press <= 1'b0;
    repeat (3) @(posedge ref_clk);
    check(init_reset_n, 1'b0);
    repeat (1000) @(posedge ref_clk);
    wait_up(100);
    repeat (4) @(posedge ref_clk);
    check(internal_logic_supply, 1'b0);
    check(core_init.irq_block, 1'b1);
    complete_run();
  end
endmodule : irg_reset_gen_tb

bind irg_reset_gen irg_reset_monitor #(.SLOW_RC(SLOW_RC)) i_irg_reset_monitor (.*);
`default_nettype wire
